/* File: rtl/s3d_defs.vh */
// Constants for the sinc3 decimation and settling control block.
// Included by the design files; holds definitions only.
`ifndef S3D_DEFS_VH
`define S3D_DEFS_VH

// Register byte offsets
`define S3D_ADDR_FILT_CFG 8'h00
`define S3D_ADDR_MODE 8'h04
`define S3D_ADDR_STATUS 8'h08
`define S3D_ADDR_DATA 8'h0C

// Filter configuration fields
`define S3D_CFG_MAP_BIT 15
`define S3D_CFG_SINC5_BIT 16
`define S3D_CFG_VAL_MSB 14
`define S3D_CFG_RESET 17'h0_0000

// Mode register fields
`define S3D_MODE_SSC_BIT 0
`define S3D_MODE_MULTI_BIT 1
`define S3D_MODE_RESET 2'h0

// Status register fields
`define S3D_ST_AVAIL_BIT 0
`define S3D_ST_SETTLED_BIT 1
`define S3D_ST_OVERRUN_BIT 2
`define S3D_ST_SSC_EFF_BIT 3
`define S3D_ST_ZERO_BIT 4

// Rates and settling
`define S3D_MOD_RATE_HZ 8000000
`define S3D_MOD_PER_UNIT 32
`define S3D_SETTLE_PERIODS 3
`define S3D_CLK_HZ 10000000

// Rate code at or above which the sinc5 path runs at 10 kSPS or below
`define S3D_CODE_10K 5'h07
`define S3D_CODE_MAX 5'h11

`endif

/* File: rtl/s3d_buf.v */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "s3d_defs.vh"

module s3d_buf
#(
  parameter W = 24,
  parameter DEPTH = 2
)
(
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out
);

  reg [W-1:0] mem_q [0:DEPTH-1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  // Honest full and empty from the entry count
  assign in_ready_out = (count_q < DEPTH);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Entry storage, no reset needed on data
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_ent
      always @(posedge clock_in)
      begin
        if (push && (wr_ptr_q == gi))
          mem_q[gi] <= in_data_in;
      end
    end
  endgenerate

  // Pointers and count
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

/* File: rtl/s3d_filter.v */
// Sinc3 decimation filter with rate selection, direct decimation mapping
// and single-cycle settling; results are read through a small register port.
// Assumes modulator bits arrive synchronous to clock_in with a valid strobe
// at the modulator rate, which stays below the 10 MHz system clock.
//
// Behaviour
// - Sinc3 needs three output periods to settle.
// - Map bit set makes the config field a direct decimation value.
// - Mapped rate is modulator rate over 32 times config bits 14:0.
// - Single-cycle settle outputs only settled results, one per settling time.
// - Single-cycle settle ignored for sinc5+sinc1 at rate codes of 10 kSPS or below, not with the map bit set.
// - Without single-cycle settle, results settle three cycles after a step.
// - Rates include 250 kSPS; single-cycle or multichannel gives one third.
`timescale 1ns/100ps
`include "s3d_defs.vh"

module s3d_filter
#(
  parameter OUT_W = 24,
  parameter ACC_W = 64
)
(
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Modulator bitstream
  input wire mod_bit_in,
  input wire mod_valid_in,
  // Register port
  input wire [7:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rd_data_out,
  // Result waiting
  output reg data_ready_out
);

  reg [16:0] filter_config_reg_q;
  reg [1:0] mode_q;
  reg [ACC_W-1:0] int1_q, int2_q, int3_q;
  reg [ACC_W-1:0] dly1_q, dly2_q, dly3_q;
  reg [19:0] samp_cnt_q;
  reg [1:0] res_cnt_q;
  reg settled_q;
  reg overrun_q;
  reg pend_valid_q;
  reg [OUT_W:0] pend_data_q;
  reg comb_fire_q;
  reg [ACC_W-1:0] comb_out_q;

  wire direct_decimation_map = filter_config_reg_q[`S3D_CFG_MAP_BIT];
  wire sinc5_sel = filter_config_reg_q[`S3D_CFG_SINC5_BIT];
  wire [4:0] rate_code = filter_config_reg_q[4:0];
  wire single_cycle_settle = mode_q[`S3D_MODE_SSC_BIT];
  wire multi_chan = mode_q[`S3D_MODE_MULTI_BIT];

  // Rate code to decimation in units of 32 modulator samples
  function [14:0] code_to_dec;
    input [4:0] code;
    begin
      case (code)
        5'h00: code_to_dec = 15'h0001; // 250 kSPS
        5'h01: code_to_dec = 15'h0002;
        5'h02: code_to_dec = 15'h0004;
        5'h03: code_to_dec = 15'h0005;
        5'h04: code_to_dec = 15'h0008;
        5'h05: code_to_dec = 15'h000A;
        5'h06: code_to_dec = 15'h0010;
        5'h07: code_to_dec = 15'h0019; // 10 kSPS
        5'h08: code_to_dec = 15'h0032;
        5'h09: code_to_dec = 15'h0064;
        5'h0A: code_to_dec = 15'h00FA;
        5'h0B: code_to_dec = 15'h01F4;
        5'h0C: code_to_dec = 15'h0271; // 400 SPS
        5'h0D: code_to_dec = 15'h04E2;
        5'h0E: code_to_dec = 15'h1388; // 50 SPS
        5'h0F: code_to_dec = 15'h30D4;
        5'h10: code_to_dec = 15'h61A8;
        default: code_to_dec = 15'h7FFF; // Slowest the field can express
      endcase
    end
  endfunction

  // Ceiling log2 of the decimation in modulator samples
  function [4:0] clog2_dec;
    input [19:0] val;
    integer k;
    begin
      clog2_dec = 5'h00;
      for (k = 0; k < 20; k = k + 1)
        if ((20'h0_0001 << k) < val)
          clog2_dec = k[4:0] + 5'h01;
    end
  endfunction

  // Decimation select: direct value replaces every other option
  wire [14:0] dec_units = direct_decimation_map ? filter_config_reg_q[14:0]
                                                : code_to_dec(rate_code);
  wire dec_zero = (dec_units == 15'h0000);
  wire [19:0] dec_samples = {dec_units, 5'h00};
  wire [4:0] dec_lg = clog2_dec(dec_samples);
  wire [6:0] norm_sh = 7'h3E - {dec_lg, 1'b0} - {2'b00, dec_lg};

  // Sinc5 path at rate codes of 10 kSPS or below keeps its own settling; mapped rates do not
  wire ssc_eff = single_cycle_settle & ~(sinc5_sel & ~direct_decimation_map &
                 (rate_code >= `S3D_CODE_10K));
  wire third_rate = ssc_eff | multi_chan;

  wire cfg_wr = wr_in & ((addr_in == `S3D_ADDR_FILT_CFG) | (addr_in == `S3D_ADDR_MODE));
  wire [ACC_W-1:0] mod_val = mod_bit_in ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};
  wire last_samp = (samp_cnt_q == dec_samples - 20'h0_0001);
  // Integrator output after this edge, so the third window holds only new samples
  wire [ACC_W-1:0] int3_nx = int3_q + int2_q;
  wire [ACC_W-1:0] c1 = int3_nx - dly1_q;
  wire [ACC_W-1:0] c2 = c1 - dly2_q;
  wire [ACC_W-1:0] c3 = c2 - dly3_q;
  wire [ACC_W-1:0] norm = comb_out_q << norm_sh;
  wire [1:0] res_next = res_cnt_q + 2'h1;
  wire emit_third = (res_next == `S3D_SETTLE_PERIODS);
  wire settled_now = settled_q | emit_third;

  wire buf_in_ready;
  wire buf_out_valid;
  wire [OUT_W:0] buf_out_data;
  wire pop = rd_in & (addr_in == `S3D_ADDR_DATA);

  // Integrators and decimation counter; a config write restarts settling
  always @(posedge clock_in)
  begin
    if (rst_in || cfg_wr || dec_zero)
    begin
      int1_q <= {ACC_W{1'b0}};
      int2_q <= {ACC_W{1'b0}};
      int3_q <= {ACC_W{1'b0}};
      samp_cnt_q <= 20'h0_0000;
    end
    else if (mod_valid_in)
    begin
      int1_q <= int1_q + mod_val;
      int2_q <= int2_q + int1_q;
      int3_q <= int3_q + int2_q;
      samp_cnt_q <= last_samp ? 20'h0_0000 : samp_cnt_q + 20'h0_0001;
    end
  end

  // Comb section at the output rate
  always @(posedge clock_in)
  begin
    if (rst_in || cfg_wr || dec_zero)
    begin
      dly1_q <= {ACC_W{1'b0}};
      dly2_q <= {ACC_W{1'b0}};
      dly3_q <= {ACC_W{1'b0}};
      comb_out_q <= {ACC_W{1'b0}};
      comb_fire_q <= 1'b0;
    end
    else
    begin
      comb_fire_q <= mod_valid_in & last_samp;
      if (mod_valid_in && last_samp)
      begin
        dly1_q <= int3_nx;
        dly2_q <= c1;
        dly3_q <= c2;
        comb_out_q <= c3;
      end
    end
  end

  // Result gating: every third result in slow modes, every result otherwise; settled flag in all modes
  always @(posedge clock_in)
  begin
    if (rst_in || cfg_wr || dec_zero)
    begin
      res_cnt_q <= 2'h0;
      settled_q <= 1'b0;
    end
    else if (comb_fire_q)
    begin
      res_cnt_q <= emit_third ? 2'h0 : res_next;
      settled_q <= settled_now;
    end
  end

  // Pending word waits for buffer room; the modulator cannot be stalled
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pend_valid_q <= 1'b0;
      pend_data_q <= {(OUT_W+1){1'b0}};
      overrun_q <= 1'b0;
    end
    else
    begin
      if (comb_fire_q && (!third_rate || emit_third))
      begin
        pend_valid_q <= 1'b1;
        pend_data_q <= {settled_now, norm[ACC_W-1 -: OUT_W]};
      end
      else if (buf_in_ready)
        pend_valid_q <= 1'b0;
      // New result over an unaccepted one; set wins over the read clear
      if (comb_fire_q && pend_valid_q && !buf_in_ready &&
          (!third_rate || emit_third))
        overrun_q <= 1'b1;
      else if (rd_in && (addr_in == `S3D_ADDR_STATUS))
        overrun_q <= 1'b0;
    end
  end

  s3d_buf #(
    .W(OUT_W + 1),
    .DEPTH(2)
  ) u_buf (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(pend_valid_q),
    .in_ready_out(buf_in_ready),
    .in_data_in(pend_data_q),
    .out_valid_out(buf_out_valid),
    .out_ready_in(pop),
    .out_data_out(buf_out_data)
  );

  // Register writes
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      filter_config_reg_q <= `S3D_CFG_RESET;
      mode_q <= `S3D_MODE_RESET;
    end
    else if (wr_in)
    begin
      if (addr_in == `S3D_ADDR_FILT_CFG)
        filter_config_reg_q <= wr_data_in[16:0];
      if (addr_in == `S3D_ADDR_MODE)
        mode_q <= wr_data_in[1:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= 32'h0000_0000;
      data_ready_out <= 1'b0;
    end
    else
    begin
      data_ready_out <= buf_out_valid;
      rd_data_out <= 32'h0000_0000;
      if (rd_in)
      begin
        case (addr_in)
          `S3D_ADDR_FILT_CFG: rd_data_out <= {15'h0000, filter_config_reg_q};
          `S3D_ADDR_MODE: rd_data_out <= {30'h0000_0000, mode_q};
          `S3D_ADDR_STATUS: rd_data_out <= {27'h000_0000, dec_zero, ssc_eff,
                                            overrun_q, settled_q, buf_out_valid};
          `S3D_ADDR_DATA: rd_data_out <= buf_out_valid ?
                                         {7'h00, buf_out_data} : 32'h0000_0000;
          default: rd_data_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: dv/s3d_mod.sv */
// Modulator model: a bit on 4 of 5 clocks, ones density 3/4.
// Assumes the 10 MHz clock of the filter.
`timescale 1ns/100ps
module s3d_mod
(
  // Clock and control
  input wire clock_in,
  input wire run_in,
  // Bitstream
  output wire mod_bit_out,
  output wire mod_valid_out
);
  reg [2:0] ph_q = 3'h0;
  reg [1:0] pat_q = 2'h0;
  // 4 of 5 clocks is 8 MHz; period 4 keeps every window exact
  assign mod_valid_out = run_in && ph_q != 3'h4;
  // Line follows phase bit 0 between samples so no stale bit passes as data
  assign mod_bit_out = mod_valid_out ? pat_q != 2'h0 : ph_q[0];
  // Phase and pattern advance
  always @(posedge clock_in)
  begin
    ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
    pat_q <= pat_q + {1'b0, mod_valid_out};
  end
endmodule

/* File: dv/s3d_filter_props.sv */
// Checker for the sinc3 filter; sees only its top ports.
// Assumes each scenario starts from reset, so no stale words.
`timescale 1ns/100ps
module s3d_filter_props
(
  input wire clock_in,
  input wire rst_in,
  input wire mod_bit_in,
  input wire mod_valid_in,
  input wire [7:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rd_data_out,
  input wire data_ready_out
);
  reg [15:0] samp_q;
  reg [16:0] cfg_q;
  reg [1:0] mode_q;
  // Shadow of the config and a sample count since restart
  wire cfg_wr = wr_in && (addr_in == 8'h00 || addr_in == 8'h04);
  wire ssc_eff = mode_q[0] && !(cfg_q[16] && !cfg_q[15] && cfg_q[4:0] >= 5'h07);
  wire ssc_any = ssc_eff || mode_q[1];
  wire zero_d = cfg_q[15] && cfg_q[14:0] == 15'h0000;
  wire [15:0] min_w = cfg_q[15] ? {cfg_q[10:0], 5'h00} : 16'h0020;
  wire rd_st = rd_in && addr_in == 8'h08;
  // Count saturates so long runs never wrap back under a floor
  always @(posedge clock_in)
  begin
    if (rst_in || cfg_wr)
      samp_q <= 16'h0000;
    else if (mod_valid_in && samp_q != 16'hFFFF)
      samp_q <= samp_q + 16'h0001;
    if (rst_in)
      cfg_q <= 17'h0_0000;
    else if (wr_in && addr_in == 8'h00)
      cfg_q <= wr_data_in[16:0];
    if (rst_in)
      mode_q <= 2'h0;
    else if (wr_in && addr_in == 8'h04)
      mode_q <= wr_data_in[1:0];
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  sequence s_data_rd;
    rd_in && addr_in == 8'h0C;
  endsequence
  sequence s_settled_word;
    s_data_rd ##1 rd_data_out[24];
  endsequence
  a_read_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_reset_quiet: assert property ($past(rst_in) |-> !data_ready_out)
    else $error("result flagged right after reset");
  a_rate_floor: assert property
    ($rose(data_ready_out) && !ssc_any |-> samp_q >= min_w)
    else $error("result before a full decimation");
  a_ssc_floor: assert property
    ($rose(data_ready_out) && ssc_any |-> samp_q >= 3 * min_w)
    else $error("single-cycle result too early");
  a_settle_count: assert property (s_settled_word |-> samp_q >= 3 * min_w)
    else $error("settled before three periods");
  a_ssc_settled: assert property
    (s_data_rd ##1 (ssc_eff && rd_data_out != 32'h0000_0000) |-> rd_data_out[24])
    else $error("unsettled word in single-cycle mode");
  a_ssc_gate: assert property (rd_st |=> rd_data_out[3] == $past(ssc_eff))
    else $error("single-cycle effect flag wrong");
  a_zero_flag: assert property (rd_st |=> rd_data_out[4] == $past(zero_d))
    else $error("zero decimation flag wrong");
  a_zero_silent: assert property (zero_d |-> !$rose(data_ready_out))
    else $error("result with zero decimation");
endmodule

/* File: dv/tb.sv */
// Testbench: register port calls against a modulator model.
// Assumes one 10 MHz clock for filter and model.
`timescale 1ns/100ps
module tb;
  reg clock_in = 1'b0;
  reg rst_in = 1'b1;
  reg run = 1'b1;
  reg [7:0] addr_in = 8'h00;
  reg [31:0] wr_data_in = 32'h0000_0000;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  wire mod_bit_in;
  wire mod_valid_in;
  wire [31:0] rd_data_out;
  wire data_ready_out;
  integer fail_count = 0;
  integer check_count = 0;
  integer i;
  // Settled half scale after the normalising shift
  localparam [31:0] HALF_SET = 32'h0120_0000;
  // Clock
  initial
  begin
    forever #50 clock_in = ~clock_in;
  end
  s3d_mod i_s3d_mod (.clock_in(clock_in), .run_in(run), .mod_bit_out(mod_bit_in),
    .mod_valid_out(mod_valid_in));
  s3d_filter i_s3d_filter (.clock_in(clock_in), .rst_in(rst_in), .mod_bit_in(mod_bit_in),
    .mod_valid_in(mod_valid_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .data_ready_out(data_ready_out));
  task final_report;
  begin
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task rst;
  begin
    rst_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  end
  endtask
  // Read data stand only in the cycle after the strobe
  task rc(input [7:0] a, input [31:0] m, input [31:0] e);
  begin
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    chk(rd_data_out & m, e);
    @(posedge clock_in);
  end
  endtask
  // Wait for a result; s samples give s*5/4 clocks at 4 of 5
  task wt(input integer s);
    integer n;
  begin
    n = 0;
    @(negedge clock_in);
    while (data_ready_out !== 1'b1 && n < 900)
    begin
      @(negedge clock_in);
      n = n + 1;
    end
    if (n >= 900)
    begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: no result", $time);
      final_report;
    end
    else
    begin
      if (s > 0)
        chk({31'h0000_0000, n >= s * 5 / 4 - 6 && n <= s * 5 / 4 + 8}, 32'h0000_0001);
      @(posedge clock_in);
    end
  end
  endtask
  initial
  begin
    rst;
    rc(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    rc(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    rc(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h00, 32'h0001_8005);
    rc(8'h00, 32'hFFFF_FFFF, 32'h0001_8005);
    // Default rate: two unsettled words, then a settled one
    rst;
    for (i = 0; i < 3; i = i + 1)
    begin
      wt(i == 0 ? 32 : 0);
      rc(8'h0C, i < 2 ? 32'h0100_0000 : 32'hFFFF_FFFF, i < 2 ? 0 : HALF_SET);
    end
    // Single-cycle, then multichannel: one settled word per three periods
    for (i = 1; i < 3; i = i + 1)
    begin
      rst;
      wr(8'h04, i[31:0]);
      rc(8'h08, 32'h0000_0008, i == 1 ? 32'h0000_0008 : 0);
      wt(96);
      rc(8'h0C, 32'hFFFF_FFFF, HALF_SET);
    end
    rst;
    wr(8'h00, 32'h0001_8002);
    wt(64);
    rst;
    wr(8'h00, 32'h0000_8000);
    rc(8'h08, 32'h0000_0010, 32'h0000_0010);
    repeat (200) @(posedge clock_in);
    rc(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h00, 32'h0001_0007);
    wr(8'h04, 32'h0000_0001);
    rc(8'h08, 32'h0000_0008, 32'h0000_0000);
    wr(8'h00, 32'h0001_0006);
    rc(8'h08, 32'h0000_0008, 32'h0000_0008);
    // Host stalls: buffer fills, overrun sticks, then drains empty
    rst;
    repeat (300) @(posedge clock_in);
    run <= 1'b0;
    repeat (60) @(posedge clock_in);
    rc(8'h08, 32'h0000_0005, 32'h0000_0005);
    rc(8'h08, 32'h0000_0004, 32'h0000_0000);
    rc(8'h0C, 32'h0100_0000, 32'h0000_0000);
    rc(8'h0C, 32'h0100_0000, 32'h0000_0000);
    rc(8'h0C, 32'hFFFF_FFFF, HALF_SET);
    rc(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    final_report;
  end
endmodule
bind s3d_filter s3d_filter_props i_s3d_filter_props (.clock_in(clock_in),
  .rst_in(rst_in), .mod_bit_in(mod_bit_in), .mod_valid_in(mod_valid_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .data_ready_out(data_ready_out));
